/* core/mfpin_cfg.svh */
// Summary of operation
// - Function code top bit one: pin is an output driven by the selected signal.
// - Code 0x82 drives the pin with the system clock divided by thirty-two.
// - Code 0x83 drives a 40 ns strobe per watchdog expiry, low otherwise.
// - Codes 0x84-0x86 drive storage write-busy, read-busy and fault flags.
// - Codes 0x88 and 0x89 mirror system clock loop lock and stable flags.
// - Codes 0x8B/0x8C drive digital phase lock AND analog lock AND system lock per channel.
// - Code 0x8A drives the AND of both channel combined-lock signals.
// - Code 0x90 drives OR of three interrupt lines; 0x91-0x93 drive each alone.
// - Codes 0xA0-0xA3 drive the fault flag of reference input A to D.
// - Codes 0xA8-0xAB drive the valid flag of reference input A to D.
// - Codes 0xB0-0xB3 drive high when that reference is active on either loop.
// - Codes 0xC0-0xC3 drive channel 0 phase lock, frequency lock, analog lock, calibration.
// - Codes 0xC5-0xC7 drive channel 0 free-run, holdover and switchover mode.
// - Codes 0xC8-0xCB drive channel 0 history available, updated, clamp and slew limited.
// - Code 0xCC drives channel 0 distribution sync pulse.
// - Codes 0xD0-0xDB give the channel 1 indications in channel 0 order.
// - Function code top bit zero: pin is an input, never driven.
`ifndef MFPIN_CFG_SVH
`define MFPIN_CFG_SVH

// register byte offsets
`define MFP_ADDR_CODE     8'h00
`define MFP_ADDR_STATE    8'h04
`define MFP_ADDR_IRQ_STAT 8'h08
`define MFP_ADDR_IRQ_MASK 8'h0C

// reset values
`define MFP_CODE_RST      8'h00
`define MFP_MASK_RST      3'h0

// interrupt bit positions
`define MFP_IRQ_WDOG      0
`define MFP_IRQ_RISE      1
`define MFP_IRQ_RSVD      2
`define MFP_IRQ_W         3

// state register bit positions
`define MFP_ST_PIN        0
`define MFP_ST_OE         1
`define MFP_ST_RSVD       2

// function code fields and fixed codes
`define MFP_DIR_BIT       7
`define MFP_C_LOW         8'h80
`define MFP_C_HIGH        8'h81
`define MFP_C_DIV         8'h82
`define MFP_C_WDOG        8'h83
`define MFP_C_SYS_LOCK    8'h88
`define MFP_C_SYS_STABLE  8'h89
`define MFP_C_ALL_LOCK    8'h8A
`define MFP_C_CH0_LOCK    8'h8B
`define MFP_C_CH1_LOCK    8'h8C
`define MFP_C_IRQ_ANY     8'h90
`define MFP_C_CH0_SYNC    8'hCC

// timing
`define MFP_CORE_MHZ      200
`define MFP_STROBE_NS     40
`define MFP_STROBE_CYC    ((`MFP_STROBE_NS * `MFP_CORE_MHZ + 999) / 1000)
`define MFP_STROBE_W      4
`define MFP_DIV_W         5

`endif

/* core/mfpin_pkg.sv */
`include "mfpin_cfg.svh"

package mfpin_pkg;
    // whole state of the pin selector, registered as one word
    typedef struct packed {
        logic [7:0]               code;
        logic [`MFP_DIV_W-1:0]    div_cnt;
        logic [`MFP_STROBE_W-1:0] strobe_cnt;
        logic                     pin;
        logic                     oe;
        logic [`MFP_IRQ_W-1:0]    irq_status;
        logic [`MFP_IRQ_W-1:0]    irq_mask;
    } mfp_state_t;

    typedef logic [11:0] chan_status_t;
endpackage

/* core/mfpin_select.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mfpin_cfg.svh"

module mfpin_select #(
    parameter int CLK_DIV = 32,
    parameter int ADDR_W  = 8
) (
    input  wire logic                  CORE_CLK,
    input  wire logic                  RESET_N,
    input  wire logic                  PSEL,
    input  wire logic                  PENABLE,
    input  wire logic                  PWRITE,
    input  wire logic [ADDR_W-1:0]     PADDR,
    input  wire logic [31:0]           PWDATA,
    output logic      [31:0]           PRDATA,
    output logic                       PREADY,
    output logic                       PSLVERR,
    output logic                       IRQ,
    input  wire logic                  WDOG_EXPIRE,
    input  wire logic [2:0]            STORE_FLAGS,
    input  wire logic [1:0]            SYS_LOOP_FLAGS,
    input  wire logic [2:0]            INT_LINES,
    input  wire logic [3:0]            REF_FAULT,
    input  wire logic [3:0]            REF_VALID,
    input  wire logic [3:0]            REF_ACTIVE_L0,
    input  wire logic [3:0]            REF_ACTIVE_L1,
    input  wire mfpin_pkg::chan_status_t CH0_STATUS,
    input  wire mfpin_pkg::chan_status_t CH1_STATUS,
    input  wire logic                  CH0_SYNC,
    output logic                       MFP_O,
    output logic                       MFP_OE
);
    import mfpin_pkg::*;

    localparam logic [`MFP_DIV_W-1:0]    DIV_LAST = `MFP_DIV_W'(CLK_DIV - 1);
    localparam logic [`MFP_DIV_W-1:0]    DIV_HALF = `MFP_DIV_W'(CLK_DIV / 2);
    localparam logic [`MFP_STROBE_W-1:0] STROBE_LOAD = `MFP_STROBE_W'(`MFP_STROBE_CYC);

    mfp_state_t st_q;
    mfp_state_t st_d;

    logic       div_hi;
    logic       strobe_on;
    logic       sel_c;
    logic       rsvd_c;
    logic       pin_c;
    logic [1:0] ch_lock;
    logic       acc_c;
    logic [ADDR_W-1:0] addr_c;

    // divided system clock and watchdog strobe, visible whatever code is set
    assign div_hi    = (st_q.div_cnt >= DIV_HALF);
    assign strobe_on = (st_q.strobe_cnt != '0);
    assign acc_c     = PSEL & PENABLE;
    assign addr_c    = PADDR;

    // per-channel combined lock: digital phase lock, analog lock, system lock
    for (genvar g = 0; g < 2; g++) begin : g_lock
        chan_status_t cs;
        assign cs = (g == 0) ? CH0_STATUS : CH1_STATUS;
        assign ch_lock[g] = cs[0] & cs[2] & SYS_LOOP_FLAGS[0];
    end

    // source selection from the current function code
    always_comb begin
        sel_c  = 1'b0;
        rsvd_c = 1'b0;
        case (st_q.code)
            `MFP_C_LOW:        sel_c = 1'b0;
            `MFP_C_HIGH:       sel_c = 1'b1;
            `MFP_C_DIV:        sel_c = div_hi;
            `MFP_C_WDOG:       sel_c = strobe_on;
            8'h84, 8'h85, 8'h86: sel_c = STORE_FLAGS[st_q.code[1:0]];
            `MFP_C_SYS_LOCK:   sel_c = SYS_LOOP_FLAGS[0];
            `MFP_C_SYS_STABLE: sel_c = SYS_LOOP_FLAGS[1];
            `MFP_C_ALL_LOCK:   sel_c = ch_lock[0] & ch_lock[1];
            `MFP_C_CH0_LOCK:   sel_c = ch_lock[0];
            `MFP_C_CH1_LOCK:   sel_c = ch_lock[1];
            `MFP_C_IRQ_ANY:    sel_c = |INT_LINES;
            8'h91, 8'h92, 8'h93: sel_c = INT_LINES[2'(st_q.code[1:0] - 2'h1)];
            8'hA0, 8'hA1, 8'hA2, 8'hA3: sel_c = REF_FAULT[st_q.code[1:0]];
            8'hA8, 8'hA9, 8'hAA, 8'hAB: sel_c = REF_VALID[st_q.code[1:0]];
            8'hB0, 8'hB1, 8'hB2, 8'hB3: begin
                sel_c = REF_ACTIVE_L0[st_q.code[1:0]] | REF_ACTIVE_L1[st_q.code[1:0]];
            end
            8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5,
            8'hC6, 8'hC7, 8'hC8, 8'hC9, 8'hCA, 8'hCB: begin
                sel_c = CH0_STATUS[st_q.code[3:0]];
            end
            8'hCC:             sel_c = CH0_SYNC;
            8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5,
            8'hD6, 8'hD7, 8'hD8, 8'hD9, 8'hDA, 8'hDB: begin
                sel_c = CH1_STATUS[st_q.code[3:0]];
            end
            default: begin
                // input codes land here too; the direction bit keeps them off the pin
                sel_c  = 1'b0;
                rsvd_c = st_q.code[`MFP_DIR_BIT];
            end
        endcase
    end

    // pin level only ever reaches the driver while the code says output
    assign pin_c = st_q.code[`MFP_DIR_BIT] & sel_c;

    // next-state logic: divider, strobe, pin, registers, sticky events
    always_comb begin
        logic [`MFP_IRQ_W-1:0] ev;
        logic [`MFP_IRQ_W-1:0] clr;
        ev  = '0;
        clr = '0;
        st_d = st_q;

        st_d.div_cnt = (st_q.div_cnt == DIV_LAST) ? '0 : st_q.div_cnt + 1'b1;

        // a fresh expiry restarts the strobe so it never comes out short
        if (WDOG_EXPIRE) begin
            st_d.strobe_cnt = STROBE_LOAD;
        end else if (strobe_on) begin
            st_d.strobe_cnt = st_q.strobe_cnt - 1'b1;
        end

        st_d.pin = pin_c;
        st_d.oe  = st_q.code[`MFP_DIR_BIT];

        ev[`MFP_IRQ_WDOG] = WDOG_EXPIRE;
        ev[`MFP_IRQ_RISE] = pin_c & ~st_q.pin;
        ev[`MFP_IRQ_RSVD] = rsvd_c;

        // apb writes take effect in the access cycle only
        if (acc_c && PWRITE) begin
            if (addr_c == ADDR_W'(`MFP_ADDR_CODE)) begin
                st_d.code = PWDATA[7:0];
            end else if (addr_c == ADDR_W'(`MFP_ADDR_IRQ_STAT)) begin
                clr = PWDATA[`MFP_IRQ_W-1:0];
            end else if (addr_c == ADDR_W'(`MFP_ADDR_IRQ_MASK)) begin
                st_d.irq_mask = PWDATA[`MFP_IRQ_W-1:0];
            end
        end

        // an event in the clearing cycle survives the clear
        st_d.irq_status = (st_q.irq_status & ~clr) | ev;
    end

    // the only state register of the block
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_q.code       <= `MFP_CODE_RST;
            st_q.div_cnt    <= '0;
            st_q.strobe_cnt <= '0;
            st_q.pin        <= 1'b0;
            st_q.oe         <= 1'b0;
            st_q.irq_status <= '0;
            st_q.irq_mask   <= `MFP_MASK_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // read mux; zero wait states, unmapped addresses answer with an error
    always_comb begin
        PRDATA  = 32'h0000_0000;
        PSLVERR = 1'b0;
        if (addr_c == ADDR_W'(`MFP_ADDR_CODE)) begin
            PRDATA[7:0] = st_q.code;
        end else if (addr_c == ADDR_W'(`MFP_ADDR_STATE)) begin
            PRDATA[`MFP_ST_PIN]  = st_q.pin;
            PRDATA[`MFP_ST_OE]   = st_q.oe;
            PRDATA[`MFP_ST_RSVD] = rsvd_c;
        end else if (addr_c == ADDR_W'(`MFP_ADDR_IRQ_STAT)) begin
            PRDATA[`MFP_IRQ_W-1:0] = st_q.irq_status;
        end else if (addr_c == ADDR_W'(`MFP_ADDR_IRQ_MASK)) begin
            PRDATA[`MFP_IRQ_W-1:0] = st_q.irq_mask;
        end else begin
            PSLVERR = acc_c;
        end
    end

    assign PREADY = 1'b1;
    assign IRQ    = |(st_q.irq_status & st_q.irq_mask);
    assign MFP_O  = st_q.pin;
    assign MFP_OE = st_q.oe;

    // checks on the selector
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);

    chk_out_dir: assert property (st_q.code[7] |=> MFP_OE)
        else $error("pin not driven for output code");
    chk_in_dir: assert property (!st_q.code[7] |=> (!MFP_OE && !MFP_O))
        else $error("pin driven for input code");
    chk_div_half: assert property ($rose(div_hi) |-> ##16 $fell(div_hi))
        else $error("divided clock half period wrong");
    chk_div_pin: assert property ((st_q.code == 8'h82) |=> (MFP_O == $past(div_hi)))
        else $error("divided clock not on pin");
    chk_wdog_width: assert property (WDOG_EXPIRE |=> strobe_on [*8])
        else $error("watchdog strobe too short");
    chk_wdog_end: assert property ($fell(strobe_on) |-> $past(WDOG_EXPIRE, 9) || !$past(strobe_on, 8))
        else $error("watchdog strobe too long");
    chk_store_mirror: assert property ((st_q.code == 8'h86) |=> (MFP_O == $past(STORE_FLAGS[2])))
        else $error("storage fault not mirrored");
    chk_all_lock: assert property ((st_q.code == 8'h8A) |=>
        (MFP_O == $past(CH0_STATUS[0] & CH0_STATUS[2] & CH1_STATUS[0] & CH1_STATUS[2] & SYS_LOOP_FLAGS[0])))
        else $error("combined lock wrong");
    chk_irq_any: assert property ((st_q.code == 8'h90) |=> (MFP_O == $past(|INT_LINES)))
        else $error("interrupt or wrong");
    chk_ref_active: assert property ((st_q.code[7:2] == 6'h2C) |=>
        (MFP_O == $past(REF_ACTIVE_L0[st_q.code[1:0]] | REF_ACTIVE_L1[st_q.code[1:0]])))
        else $error("reference active wrong");
    chk_ch1_map: assert property ((st_q.code == 8'hD9) |=> (MFP_O == $past(CH1_STATUS[9])))
        else $error("channel 1 history updated wrong");
    chk_rsvd_low: assert property (((st_q.code == 8'h87) || (st_q.code == 8'hDC)) |=> (MFP_OE && !MFP_O))
        else $error("reserved code not low");
    chk_wdog_sticky: assert property (WDOG_EXPIRE |=> st_q.irq_status[`MFP_IRQ_WDOG])
        else $error("watchdog event lost");

    // fixed levels: the pin is driven and holds the constant one edge later
    chk_static_low: assert property ((st_q.code == `MFP_C_LOW) |=> (MFP_OE && !MFP_O))
        else $error("static low code not low");

    chk_static_high: assert property ((st_q.code == `MFP_C_HIGH) |=> (MFP_OE && MFP_O))
        else $error("static high code not high");

    // watchdog code: pin is the strobe and nothing else
    chk_wdog_pin: assert property ((st_q.code == `MFP_C_WDOG) |=> (MFP_O == $past(strobe_on)))
        else $error("watchdog strobe not on pin");

    chk_wdog_quiet: assert property (((st_q.code == `MFP_C_WDOG) && !strobe_on) |=> !MFP_O)
        else $error("watchdog pin high without strobe");

    // storage activity and fault flags, one code per flag
    for (genvar i = 0; i < 3; i++) begin : g_chk_store
        chk_store_flag: assert property ((st_q.code == 8'(8'h84 + i)) |=> (MFP_O == $past(STORE_FLAGS[i])))
            else $error("storage flag not mirrored");
    end

    // system clock loop lock and stable flags
    for (genvar i = 0; i < 2; i++) begin : g_chk_sys
        chk_sys_flag: assert property ((st_q.code == 8'(8'h88 + i)) |=> (MFP_O == $past(SYS_LOOP_FLAGS[i])))
            else $error("system loop flag not mirrored");
    end

    // per-channel combined lock, written out from the raw bits, not from ch_lock
    chk_ch0_lock: assert property ((st_q.code == `MFP_C_CH0_LOCK) |=>
        (MFP_O == $past(CH0_STATUS[0] & CH0_STATUS[2] & SYS_LOOP_FLAGS[0])))
        else $error("channel 0 combined lock wrong");

    chk_ch1_lock: assert property ((st_q.code == `MFP_C_CH1_LOCK) |=>
        (MFP_O == $past(CH1_STATUS[0] & CH1_STATUS[2] & SYS_LOOP_FLAGS[0])))
        else $error("channel 1 combined lock wrong");

    // single interrupt lines
    for (genvar i = 0; i < 3; i++) begin : g_chk_irq
        chk_irq_line: assert property ((st_q.code == 8'(8'h91 + i)) |=> (MFP_O == $past(INT_LINES[i])))
            else $error("interrupt line not mirrored");
    end

    // reference fault and valid flags, A to D
    for (genvar i = 0; i < 4; i++) begin : g_chk_ref
        chk_ref_fault: assert property ((st_q.code == 8'(8'hA0 + i)) |=> (MFP_O == $past(REF_FAULT[i])))
            else $error("reference fault not mirrored");
        chk_ref_valid: assert property ((st_q.code == 8'(8'hA8 + i)) |=> (MFP_O == $past(REF_VALID[i])))
            else $error("reference valid not mirrored");
    end

    // channel status indications, channel 1 in the order of channel 0
    for (genvar i = 0; i < 12; i++) begin : g_chk_chan
        chk_ch0_bit: assert property ((st_q.code == 8'(8'hC0 + i)) |=> (MFP_O == $past(CH0_STATUS[i])))
            else $error("channel 0 indication wrong");
        chk_ch1_bit: assert property ((st_q.code == 8'(8'hD0 + i)) |=> (MFP_O == $past(CH1_STATUS[i])))
            else $error("channel 1 indication wrong");
    end

    chk_sync_pin: assert property ((st_q.code == `MFP_C_CH0_SYNC) |=> (MFP_O == $past(CH0_SYNC)))
        else $error("distribution sync not on pin");

    // one code out of each reserved gap except 0x87; all must hold the pin low but driven
    chk_rsvd_gaps: assert property ((st_q.code inside {8'h8D, 8'h94, 8'hA4, 8'hAC, 8'hB4, 8'hCD, 8'hFF}) |=>
        (MFP_OE && !MFP_O))
        else $error("reserved gap code not low");

    // software learns of a reserved code through the sticky flag
    chk_rsvd_flag: assert property ((st_q.code[7] && rsvd_c) |=> st_q.irq_status[`MFP_IRQ_RSVD])
        else $error("reserved code flag not set");

    cov_div_out: cover property ((st_q.code == 8'h82) && $rose(MFP_O));
    cov_wdog_out: cover property ((st_q.code == 8'h83) && $rose(MFP_O));
    cov_irq_rise: cover property ($rose(IRQ));
    cov_in_to_out: cover property ($rose(MFP_OE));
    cov_rsvd_code: cover property ($rose(rsvd_c));

endmodule // mfpin_select
`default_nettype wire

/* test/pin_monitor.sv */
`timescale 1ns/10ps
`default_nettype none

module pin_monitor (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       pin_o,
    input  wire logic       pin_oe,
    output logic            pin_wire,
    output logic [7:0]      period,
    output logic [7:0]      hi_len
);
    logic       prev_q;
    logic [7:0] since_q;
    logic [7:0] run_q;

    // board pull-down: a released pin reads low, never the last driven level
    assign pin_wire = pin_oe ? pin_o : 1'b0;

    // rise-to-rise spacing and length of the last high run, in core cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q  <= 1'b0;
            since_q <= 8'h00;
            run_q   <= 8'h00;
            period  <= 8'h00;
            hi_len  <= 8'h00;
        end else begin
            prev_q  <= pin_wire;
            since_q <= (pin_wire && !prev_q) ? 8'h01 : since_q + 8'h01;
            if (pin_wire && !prev_q) begin
                period <= since_q;
            end
            if (pin_wire) begin
                run_q <= run_q + 8'h01;
            end else if (prev_q) begin
                hi_len <= run_q; // only a finished run counts
                run_q  <= 8'h00;
            end
        end
    end
endmodule // pin_monitor

`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mfpin_cfg.svh"

module tb_top;
    import mfpin_pkg::*;
    localparam int          DIV    = 32;
    localparam int          STROBE = 40 / 5; // 40 ns at a 5 ns period
    localparam logic [48:0] ALT    = 49'hAAAA_AAAA_AAAA;
    logic        clk     = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic        wdog    = 1'b0;
    logic [48:0] src     = 49'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, irq, mfp_o, mfp_oe, pin_wire, err;
    logic [7:0]  period, hi_len;
    logic [31:0] rd;
    int          mismatches = 0;
    int          num_checks = 0;

    mfpin_select #(.CLK_DIV(DIV), .ADDR_W(8)) DUT (
        .CORE_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .IRQ(irq), .WDOG_EXPIRE(wdog), .STORE_FLAGS(src[2:0]), .SYS_LOOP_FLAGS(src[4:3]),
        .INT_LINES(src[7:5]), .REF_FAULT(src[11:8]), .REF_VALID(src[15:12]),
        .REF_ACTIVE_L0(src[19:16]), .REF_ACTIVE_L1(src[23:20]), .CH0_STATUS(src[35:24]),
        .CH1_STATUS(src[47:36]), .CH0_SYNC(src[48]), .MFP_O(mfp_o), .MFP_OE(mfp_oe));

    pin_monitor mon (.clk(clk), .rst_n(rst_n), .pin_o(mfp_o), .pin_oe(mfp_oe),
        .pin_wire(pin_wire), .period(period), .hi_len(hi_len));

    // free-running core clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    // expected pin level from the current source vector
    function automatic logic exp_pin(input logic [7:0] c);
        logic l0;
        logic l1;
        l0 = src[24] & src[26] & src[3];
        l1 = src[36] & src[38] & src[3];
        if (!c[7]) return 1'b0;
        case (c) inside
            8'h81:          return 1'b1;
            [8'h84:8'h86]:  return src[c[1:0]];
            8'h88, 8'h89:   return src[3 + c[0]];
            8'h8A:          return l0 & l1;
            8'h8B:          return l0;
            8'h8C:          return l1;
            8'h90:          return |src[7:5];
            [8'h91:8'h93]:  return src[4 + c[1:0]];
            [8'hA0:8'hA3]:  return src[8 + c[1:0]];
            [8'hA8:8'hAB]:  return src[12 + c[1:0]];
            [8'hB0:8'hB3]:  return src[16 + c[1:0]] | src[20 + c[1:0]];
            [8'hC0:8'hCB]:  return src[24 + c[3:0]];
            8'hCC:          return src[48];
            [8'hD0:8'hDB]:  return src[36 + c[3:0]];
            default:        return 1'b0;
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    // one APB transfer; the request holds until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // the pin follows a new code one edge after the store
    task automatic set_code(input logic [7:0] c);
        apb(1'b1, `MFP_ADDR_CODE, {24'h0, c});
        @(posedge clk);
        #1;
    endtask

    task automatic pulse_wdog;
        @(posedge clk);
        wdog <= 1'b1;
        @(posedge clk);
        wdog <= 1'b0;
        repeat (STROBE + 4) @(posedge clk);
        #1;
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // a hang costs far more than the few thousand cycles the tests need
    initial begin
        #100000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check({31'h0, mfp_oe}, 32'h0, "oe after reset");
        apb(1'b0, `MFP_ADDR_CODE, 32'h0);
        check(rd, 32'h0, "code reset value");
        apb(1'b0, 8'h10, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped error");
        check(rd, 32'h0, "unmapped data");
        apb(1'b1, 8'h10, 32'hFF);
        check({31'h0, err}, 32'h1, "unmapped write error");
        $display("test reset_decode done");
        // every code from the last input codes up except 0x82 and 0x83, under four source patterns
        for (int p = 0; p < 4; p++) begin
            src <= {49{p[0]}} ^ (p[1] ? ALT : 49'h0);
            for (int c = 8'h7E; c <= 8'hFF; c++) begin
                if (c != 8'h82 && c != 8'h83) begin
                    set_code(c[7:0]);
                    check({30'h0, mfp_oe, pin_wire}, {30'h0, c[7], exp_pin(c[7:0])}, "pin select");
                end
            end
        end
        // last code of the sweep is 0xFF: reserved output, driven low
        apb(1'b0, `MFP_ADDR_CODE, 32'h0);
        check(rd, 32'h0000_00FF, "code readback");
        apb(1'b0, `MFP_ADDR_STATE, 32'h0);
        check(rd, 32'h0000_0006, "state on reserved code");
        apb(1'b0, `MFP_ADDR_IRQ_STAT, 32'h0);
        check(rd & 32'h4, 32'h4, "reserved code flag");
        $display("test code_table done");
        set_code(8'h82);
        repeat (3 * DIV) @(posedge clk);
        #1;
        check({24'h0, period}, 32'(DIV), "divider period");
        check({24'h0, hi_len}, 32'(DIV / 2), "divider high time");
        $display("test divider done");
        set_code(8'h83);
        apb(1'b1, `MFP_ADDR_IRQ_MASK, 32'h1);
        apb(1'b1, `MFP_ADDR_IRQ_STAT, 32'h7);
        @(posedge clk);
        #1;
        check({31'h0, irq}, 32'h0, "irq cleared");
        pulse_wdog();
        check({24'h0, hi_len}, 32'(STROBE), "strobe width");
        check({31'h0, mfp_o}, 32'h0, "low after strobe");
        check({31'h0, irq}, 32'h1, "irq raised");
        apb(1'b1, `MFP_ADDR_IRQ_STAT, 32'h7);
        @(posedge clk);
        #1;
        check({31'h0, irq}, 32'h0, "irq after w1c");
        apb(1'b1, `MFP_ADDR_IRQ_MASK, 32'h0);
        pulse_wdog();
        check({31'h0, irq}, 32'h0, "irq masked");
        apb(1'b0, `MFP_ADDR_IRQ_STAT, 32'h0);
        check(rd & 32'h1, 32'h1, "sticky expiry");
        $display("test watchdog_irq done");
        tally_and_finish();
    end
endmodule // tb_top

`default_nettype wire
